// ==== shared/ods_pkg.sv ====
// Shared constants, register map and carrier types of the output diagnostic sequencer.
package ods_pkg;

   localparam int CH_W = 5;
   localparam int PHASE_CH = 8;
   localparam int PHASES = 3;

   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FIELD_EN = 8'h04;
   localparam logic [7:0] OFS_CH_EN = 8'h08;
   localparam logic [7:0] OFS_CH_EXT = 8'h0C;
   localparam logic [7:0] OFS_TIMING = 8'h10;
   localparam logic [7:0] OFS_POWER = 8'h14;
   localparam logic [7:0] OFS_VOLT = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam logic [7:0] OFS_FAULT = 8'h20;

   // Field positions.
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_VSEL_BIT = 4;
   localparam int CTRL_RELAY_BIT = 5;
   localparam int CTRL_JOB_BIT = 8;
   localparam int TIM_REP_LSB = 0;
   localparam int TIM_CHP_LSB = 8;
   localparam int TIM_CYP_LSB = 16;
   localparam int PWR_RATED_LSB = 0;
   localparam int PWR_DEV_LSB = 16;
   localparam int STS_STATE_LSB = 0;
   localparam int STS_CH_LSB = 8;
   localparam int STS_JOB_BIT = 16;
   localparam int STS_SKIP_BIT = 17;
   localparam int STS_PEND_BIT = 18;
   localparam int FLT_CH_LSB = 0;
   localparam int FLT_CODE_LSB = 8;
   localparam int FLT_VALID_BIT = 31;

   // Reset values.
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [31:0] RST_EN = 32'h0000_0000;
   localparam logic [31:0] RST_CH_EXT = 32'h0000_0000;
   localparam logic [31:0] RST_TIMING = 32'h0000_0000;
   localparam logic [31:0] RST_POWER = 32'h0000_0000;
   localparam logic [31:0] RST_VOLT = 32'h0000_0000;

   // Timing: channel pause step, and its cycle count at the clock rate.
   localparam int PCLK_MHZ = 250;
   localparam int PAUSE_STEP_MS = 50;
   localparam int PAUSE_STEP_CYC = PAUSE_STEP_MS * 1000 * PCLK_MHZ;

   typedef enum logic [2:0] {
      MODE_OFF = 3'h0, MODE_STARTUP = 3'h1, MODE_STANDBY = 3'h2,
      MODE_PROD1 = 3'h3, MODE_PROD2 = 3'h4
   } ods_mode_t;

   typedef enum logic [2:0] {
      FLT_NONE = 3'h0, FLT_T1 = 3'h1, FLT_T2 = 3'h2, FLT_T3 = 3'h3,
      FLT_T4 = 3'h4, FLT_T5 = 3'h5, FLT_T2EXT = 3'h6
   } ods_fault_t;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01, ST_SEEK = 7'h02, ST_WAVE1 = 7'h04, ST_WAVE2 = 7'h08,
      ST_LOCAL = 7'h10, ST_EVAL = 7'h20, ST_CPAUSE = 7'h40
   } ods_state_t;

   typedef struct packed {
      logic volt_on;
      logic ext_ok;
      logic drv_fault;
      logic [15:0] cur;
      logic [15:0] line_v;
   } ods_meas_t;

   typedef struct packed {
      logic valid;
      logic job;
      logic [CH_W-1:0] ch;
      ods_fault_t code;
   } ods_report_t;

endpackage

// ==== design/ods_classify.sv ====
// Fault classifier: turns one channel's wave samples into a fault code.
`timescale 1ns/1ps
module ods_classify (
   input wire logic relay,
   input wire logic ext,
   input wire logic vsel,
   input wire logic [15:0] pvolt,
   input wire logic [15:0] rated,
   input wire logic [15:0] dev,
   input wire logic on_seen,
   input wire logic off_seen,
   input wire logic ext_ok,
   input wire logic drv_fault,
   input wire logic [15:0] cur,
   input wire logic [15:0] line_v,
   output ods_pkg::ods_fault_t code
);
   import ods_pkg::*;

   logic [15:0] volt;
   logic [31:0] pwr;
   logic [16:0] hi;
   logic [15:0] lo;
   ods_fault_t std_code;
   ods_fault_t pwr_code;

   assign volt = vsel ? line_v : pvolt;
   assign pwr = volt * cur;
   assign hi = {1'b0, rated} + {1'b0, dev};
   assign lo = (rated > dev) ? rated - dev : 16'h0000;

   always_comb begin
      std_code = FLT_NONE;
      if (relay) begin
         if (!on_seen && drv_fault) begin
            std_code = FLT_T5;
         end else if (!on_seen) begin
            std_code = FLT_T1;
         end else if (off_seen) begin
            std_code = FLT_T2;
         end
      end else begin
         if (off_seen) begin
            std_code = FLT_T2;
         end else if (!on_seen) begin
            std_code = ext_ok ? FLT_T1 : FLT_T2EXT;
         end
      end
      pwr_code = FLT_NONE;
      if ({1'b0, pwr[31:16]} > hi) begin
         pwr_code = FLT_T4;
      end else if (pwr[31:16] < lo) begin
         pwr_code = FLT_T3;
      end
   end

   // Extended channels return no load feedback, so only power is judged, with or without a relay unit.
   assign code = ext ? pwr_code : std_code;

endmodule // ods_classify

// ==== design/ods_seq.sv ====
// Cyclic and job-triggered diagnostic sequencer for heater output channels.
`timescale 1ns/1ps
module ods_seq #(
   parameter int NUM_CH = 24,
   parameter int NUM_FIELD = 3,
   parameter int CH_PER_FIELD = 8,
   parameter int ADDR_W = 8,
   parameter int PAUSE_STEP = ods_pkg::PAUSE_STEP_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic zc_l1,
   input wire logic [NUM_CH-1:0] ctl_pattern,
   input wire logic [NUM_CH-1:0] ch_present,
   input wire ods_pkg::ods_meas_t meas,
   output logic [NUM_CH-1:0] sw_out,
   output logic meas_cur_en,
   output ods_pkg::ods_report_t report
);
   import ods_pkg::*;

   typedef struct packed {
      ods_state_t st;
      logic [CH_W-1:0] ch;
      logic job;
      logic job_pend;
      logic skip;
      logic done;
      logic [7:0] cyc_left;
      logic [7:0] pcnt;
      logic [31:0] tcnt;
      logic on_seen;
      logic off_seen;
      logic ext_ok;
      logic drv;
      logic [15:0] cur;
      logic [15:0] lv;
      logic [NUM_CH-1:0][7:0] rep;
      ods_report_t rpt;
      ods_report_t flt;
      logic [NUM_CH-1:0] sw;
      logic cur_en;
      logic ack;
      logic [31:0] rdata;
      logic [2:0] mode;
      logic vsel;
      logic relay;
      logic [NUM_FIELD-1:0] fen;
      logic [NUM_CH-1:0] cen;
      logic [NUM_CH-1:0] cext;
      logic [7:0] rep_cfg;
      logic [7:0] chp_cfg;
      logic [7:0] cyp_cfg;
      logic [15:0] rated;
      logic [15:0] dev;
      logic [15:0] pvolt;
      logic zc_m;
      logic zc_s;
      logic zc_p;
   } ods_core_t;

   ods_core_t s;
   ods_core_t n;
   ods_fault_t cls_code;
   logic zc_tick;
   logic mode_ok;
   logic incl;
   logic last;
   logic ext;
   logic hit;
   logic wr;
   logic [31:0] rv;
   logic [NUM_CH-1:0] t1h;
   logic [NUM_CH-1:0] pm;
   logic [NUM_CH-1:0] en;
   logic [NUM_CH-1:0] val;

   function automatic int fld_of(input logic [CH_W-1:0] c);
      return int'(c) / CH_PER_FIELD;
   endfunction

   function automatic logic [NUM_CH-1:0] ph_mask(input logic [CH_W-1:0] c);
      logic [NUM_CH-1:0] m;
      m = '0;
      for (int k = 0; k < NUM_CH; k++) begin
         m[k] = ((k % (PHASE_CH * PHASES)) / PHASE_CH) ==
                ((int'(c) % (PHASE_CH * PHASES)) / PHASE_CH);
      end
      return m;
   endfunction

   assign zc_tick = s.zc_s & ~s.zc_p;
   assign mode_ok = (s.mode == MODE_STANDBY) || (s.mode == MODE_PROD1) ||
                    (s.mode == MODE_PROD2);
   assign incl = s.job ? ch_present[s.ch] : (s.cen[s.ch] & s.fen[fld_of(s.ch)]);
   assign last = s.ch == CH_W'(NUM_CH - 1);
   assign ext = s.cext[s.ch];
   assign hit = (paddr == ADDR_W'(OFS_CTRL)) || (paddr == ADDR_W'(OFS_FIELD_EN)) ||
                (paddr == ADDR_W'(OFS_CH_EN)) || (paddr == ADDR_W'(OFS_CH_EXT)) ||
                (paddr == ADDR_W'(OFS_TIMING)) || (paddr == ADDR_W'(OFS_POWER)) ||
                (paddr == ADDR_W'(OFS_VOLT)) || (paddr == ADDR_W'(OFS_STATUS)) ||
                (paddr == ADDR_W'(OFS_FAULT));
   assign pready = psel & penable & s.ack & ce;
   assign pslverr = pready & ~hit;
   assign wr = pready & pwrite & hit;
   assign prdata = s.rdata;
   assign sw_out = s.sw;
   assign meas_cur_en = s.cur_en;
   assign report = s.rpt;

   ods_classify u_cls (
      .relay(s.relay),
      .ext(ext),
      .vsel(s.vsel),
      .pvolt(s.pvolt),
      .rated(s.rated),
      .dev(s.dev),
      .on_seen(s.on_seen),
      .off_seen(s.off_seen),
      .ext_ok(s.ext_ok),
      .drv_fault(s.drv),
      .cur(s.cur),
      .line_v(s.lv),
      .code(cls_code)
   );

   always_comb begin
      n = s;
      rv = '0;
      n.rpt.valid = 1'b0;
      n.zc_m = zc_l1;
      n.zc_s = s.zc_m;
      n.zc_p = s.zc_s;
      // Read data is captured in the first access cycle, so pready comes one cycle later.
      if (psel && penable && !s.ack) begin
         n.ack = 1'b1;
         if (paddr == ADDR_W'(OFS_CTRL)) begin
            rv[CTRL_MODE_LSB +: 3] = s.mode;
            rv[CTRL_VSEL_BIT] = s.vsel;
            rv[CTRL_RELAY_BIT] = s.relay;
            rv[CTRL_JOB_BIT] = s.job_pend | s.job;
         end else if (paddr == ADDR_W'(OFS_FIELD_EN)) begin
            rv[NUM_FIELD-1:0] = s.fen;
         end else if (paddr == ADDR_W'(OFS_CH_EN)) begin
            rv[NUM_CH-1:0] = s.cen;
         end else if (paddr == ADDR_W'(OFS_CH_EXT)) begin
            rv[NUM_CH-1:0] = s.cext;
         end else if (paddr == ADDR_W'(OFS_TIMING)) begin
            rv = {8'h00, s.cyp_cfg, s.chp_cfg, s.rep_cfg};
         end else if (paddr == ADDR_W'(OFS_POWER)) begin
            rv = {s.dev, s.rated};
         end else if (paddr == ADDR_W'(OFS_VOLT)) begin
            rv[15:0] = s.pvolt;
         end else if (paddr == ADDR_W'(OFS_STATUS)) begin
            rv[STS_STATE_LSB +: 7] = s.st;
            rv[STS_CH_LSB +: CH_W] = s.ch;
            rv[STS_JOB_BIT] = s.job;
            rv[STS_SKIP_BIT] = s.skip;
            rv[STS_PEND_BIT] = s.job_pend;
         end else if (paddr == ADDR_W'(OFS_FAULT)) begin
            rv[FLT_CH_LSB +: CH_W] = s.flt.ch;
            rv[FLT_CODE_LSB +: 3] = s.flt.code;
            rv[FLT_VALID_BIT] = s.flt.valid;
         end
         n.rdata = rv;
      end
      if (pready) begin
         n.ack = 1'b0;
      end
      // Clearing the stored fault comes first so that a fault found in the same cycle wins.
      if (wr && paddr == ADDR_W'(OFS_FAULT) && pwdata[FLT_VALID_BIT]) begin
         n.flt.valid = 1'b0;
      end
      case (s.st)
         ST_IDLE: begin
            if (s.job_pend) begin
               n.job_pend = 1'b0;
               n.job = 1'b1;
               n.skip = 1'b0;
               n.done = 1'b0;
               n.ch = '0;
               n.st = ST_SEEK;
            end else if (mode_ok) begin
               n.st = ST_SEEK;
            end
         end
         ST_SEEK: begin
            if (s.job_pend && !s.job) begin
               n.job_pend = 1'b0;
               n.job = 1'b1;
               n.skip = 1'b0;
               n.done = 1'b0;
               n.ch = '0;
            end else if (s.done || !incl) begin
               n.done = 1'b0;
               n.ch = last ? '0 : CH_W'(s.ch + 1);
               if (last && s.job) begin
                  n.job = 1'b0;
                  n.st = ST_IDLE;
               end else if (last && s.skip) begin
                  n.cyc_left = s.cyc_left - 8'h01;
                  n.skip = s.cyc_left > 8'h01;
               end else if (last) begin
                  n.cyc_left = s.cyp_cfg;
                  n.skip = s.cyp_cfg != 8'h00;
               end
            end else if (zc_tick) begin
               n.st = ST_WAVE1;
            end
         end
         ST_WAVE1: begin
            if (zc_tick) begin
               if (ext) begin
                  n.off_seen = meas.volt_on;
               end else begin
                  n.on_seen = meas.volt_on;
                  n.drv = meas.drv_fault;
               end
               n.st = ST_WAVE2;
            end
         end
         ST_WAVE2: begin
            if (zc_tick) begin
               n.st = ST_EVAL;
               if (ext) begin
                  n.on_seen = meas.volt_on;
                  n.drv = meas.drv_fault;
                  n.cur = meas.cur;
                  n.lv = meas.line_v;
               end else begin
                  n.off_seen = meas.volt_on;
                  if (!s.skip && (!s.on_seen || meas.volt_on)) begin
                     n.st = ST_LOCAL;
                  end
               end
            end
         end
         ST_LOCAL: begin
            if (zc_tick) begin
               n.ext_ok = meas.ext_ok;
               n.cur = meas.cur;
               n.lv = meas.line_v;
               n.st = ST_EVAL;
            end
         end
         ST_EVAL: begin
            if (!s.skip && s.job && cls_code != FLT_NONE) begin
               n.rpt = '{valid: 1'b1, job: 1'b1, ch: s.ch, code: cls_code};
            end else if (!s.skip && cls_code != FLT_NONE) begin
               if (s.rep[s.ch] >= s.rep_cfg) begin
                  n.rpt = '{valid: 1'b1, job: 1'b0, ch: s.ch, code: cls_code};
                  n.flt = n.rpt;
               end else begin
                  n.rep[s.ch] = s.rep[s.ch] + 8'h01;
               end
            end else if (!s.skip) begin
               n.rep[s.ch] = 8'h00;
            end
            n.done = 1'b1;
            n.pcnt = s.chp_cfg;
            n.tcnt = '0;
            n.st = s.job ? ST_SEEK : ST_CPAUSE;
         end
         ST_CPAUSE: begin
            if (s.pcnt == 8'h00) begin
               n.st = ST_SEEK;
            end else if (s.tcnt == 32'(PAUSE_STEP - 1)) begin
               n.tcnt = '0;
               n.pcnt = s.pcnt - 8'h01;
            end else begin
               n.tcnt = s.tcnt + 32'h1;
            end
         end
         default: n.st = ST_IDLE;
      endcase
      if (!n.job && !mode_ok) begin
         n.st = ST_IDLE;
      end
      if (wr && paddr == ADDR_W'(OFS_CTRL)) begin
         n.mode = pwdata[CTRL_MODE_LSB +: 3];
         n.vsel = pwdata[CTRL_VSEL_BIT];
         n.relay = pwdata[CTRL_RELAY_BIT];
         if (pwdata[CTRL_JOB_BIT]) begin
            n.job_pend = 1'b1;
         end
      end else if (wr && paddr == ADDR_W'(OFS_FIELD_EN)) begin
         n.fen = pwdata[NUM_FIELD-1:0];
      end else if (wr && paddr == ADDR_W'(OFS_CH_EN)) begin
         n.cen = pwdata[NUM_CH-1:0];
      end else if (wr && paddr == ADDR_W'(OFS_CH_EXT)) begin
         n.cext = pwdata[NUM_CH-1:0];
      end else if (wr && paddr == ADDR_W'(OFS_TIMING)) begin
         n.rep_cfg = pwdata[TIM_REP_LSB +: 8];
         n.chp_cfg = pwdata[TIM_CHP_LSB +: 8];
         n.cyp_cfg = pwdata[TIM_CYP_LSB +: 8];
      end else if (wr && paddr == ADDR_W'(OFS_POWER)) begin
         n.rated = pwdata[PWR_RATED_LSB +: 16];
         n.dev = pwdata[PWR_DEV_LSB +: 16];
      end else if (wr && paddr == ADDR_W'(OFS_VOLT)) begin
         n.pvolt = pwdata[15:0];
      end
      // Switching override of the channel under test and, where asked, its phase.
      t1h = '0;
      t1h[s.ch] = 1'b1;
      pm = ph_mask(s.ch);
      en = '0;
      val = '0;
      if (!s.skip && s.st == ST_WAVE1) begin
         en = t1h;
         val = ext ? '0 : t1h;
      end else if (!s.skip && s.st == ST_WAVE2) begin
         en = ext ? pm : t1h;
         val = ext ? t1h : '0;
      end else if (!s.skip && s.st == ST_LOCAL) begin
         en = pm;
      end
      n.sw = (ctl_pattern & ~en) | (val & en);
      n.cur_en = !s.skip && ((s.st == ST_WAVE2 && ext) || s.st == ST_LOCAL);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.st <= ST_IDLE;
         s.mode <= RST_CTRL[CTRL_MODE_LSB +: 3];
         s.fen <= RST_EN[NUM_FIELD-1:0];
         s.cen <= RST_EN[NUM_CH-1:0];
         s.cext <= RST_CH_EXT[NUM_CH-1:0];
         s.rep_cfg <= RST_TIMING[TIM_REP_LSB +: 8];
         s.rated <= RST_POWER[PWR_RATED_LSB +: 16];
         s.pvolt <= RST_VOLT[15:0];
      end else if (ce) begin
         s <= n;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_skip;
      (ce && s.st == ST_SEEK && !incl && !s.job_pend && mode_ok) |=> s.st != ST_WAVE1;
   endproperty
   a_skip: assert property (p_skip) else $error("Disabled channel was tested.");

   property p_advance;
      (ce && s.st == ST_SEEK && !incl && !s.job_pend && !last && mode_ok) |=>
         s.ch == $past(s.ch) + 5'h01;
   endproperty
   a_advance: assert property (p_advance) else $error("Skip did not advance.");

   property p_std_pulse;
      (ce && s.st == ST_WAVE1 && !s.skip && !ext) |=> sw_out[$past(s.ch)];
   endproperty
   a_std_pulse: assert property (p_std_pulse) else $error("Channel not pulsed.");

   property p_local_off;
      (ce && s.st == ST_LOCAL) |=> (sw_out & $past(pm)) == '0;
   endproperty
   a_local_off: assert property (p_local_off) else $error("Phase not off.");

   property p_ext_alone;
      (ce && s.st == ST_WAVE2 && ext && !s.skip) |=> (sw_out & $past(pm)) == $past(t1h);
   endproperty
   a_ext_alone: assert property (p_ext_alone) else $error("Extended wave wrong.");

   property p_cur_std;
      (ce && s.st == ST_WAVE2 && !ext) |=> !meas_cur_en;
   endproperty
   a_cur_std: assert property (p_cur_std) else $error("Current on standard.");

   property p_suspend;
      (ce && !mode_ok && !s.job && !s.job_pend) |=> s.st == ST_IDLE;
   endproperty
   a_suspend: assert property (p_suspend) else $error("Cyclic run outside mode.");

   property p_repeat;
      (ce && s.st == ST_EVAL && !s.job && s.rep[s.ch] < s.rep_cfg) |=> !report.valid;
   endproperty
   a_repeat: assert property (p_repeat) else $error("Unconfirmed report.");

   property p_pause;
      (ce && s.st == ST_CPAUSE && s.pcnt != 8'h00 && mode_ok) |=> s.st == ST_CPAUSE;
   endproperty
   a_pause: assert property (p_pause) else $error("Pause ended early.");

   property p_job_nostore;
      (ce && s.st == ST_EVAL && s.job) |=> $stable(s.flt) ##0 s.st == ST_SEEK;
   endproperty
   a_job_nostore: assert property (p_job_nostore) else $error("Job stored a fault.");

   property p_zc_wave;
      (ce && s.st == ST_WAVE1 && !zc_tick && mode_ok) |=> s.st == ST_WAVE1;
   endproperty
   a_zc_wave: assert property (p_zc_wave) else $error("Wave left off crossing.");

   property p_resume;
      (ce && s.st == ST_IDLE) |=> sw_out == $past(ctl_pattern);
   endproperty
   a_resume: assert property (p_resume) else $error("Normal pattern lost.");

   c_job_report: cover property (report.valid && report.job);
   c_cyc_report: cover property (report.valid && !report.job);
   c_local: cover property (s.st == ST_LOCAL ##1 s.st == ST_EVAL);
   c_skip_cycle: cover property (s.skip && s.st == ST_WAVE2);

endmodule // ods_seq

// ==== test/ods_mains_master.sv ====
// Far-side model: first-phase mains zero-crossing source and fieldbus report collector.
`timescale 1ns/1ps
module ods_mains_master #(
   parameter int HALF = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire ods_pkg::ods_report_t report,
   output logic zc_l1,
   output int rep_cnt,
   output ods_pkg::ods_report_t last
);
   import ods_pkg::*;
   int ph;
   // Mains keeps running whatever the bus does, so the square wave is free-running.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph <= 0;
         zc_l1 <= 1'b0;
      end else begin
         ph <= (ph == HALF - 1) ? 0 : ph + 1;
         if (ph == HALF - 1) begin
            zc_l1 <= ~zc_l1;
         end
      end
   end
   // The master keeps only the newest report and a count of all received.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rep_cnt <= 0;
         last <= '0;
      end else if (report.valid === 1'b1) begin
         rep_cnt <= rep_cnt + 1;
         last <= report;
      end
   end
endmodule // ods_mains_master

// ==== test/tb_top.sv ====
// Self-checking testbench for the diagnostic sequencer.
`timescale 1ns/1ps
module tb_top;
   import ods_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic zc_l1;
   logic [23:0] ctl_pattern = 24'hA5C3F0;
   logic [23:0] ch_present = 24'h000000;
   ods_meas_t meas = '0;
   logic [23:0] sw_out;
   logic meas_cur_en;
   ods_report_t report;
   ods_report_t last;
   int rep_cnt;
   int miscompares = 0;
   int total_checks = 0;
   logic [31:0] rd;
   logic err;
   logic cur_seen = 1'b0;

   always #2 pclk = ~pclk;

   // Remembers whether any current measurement window was opened.
   always @(posedge pclk) begin
      if (meas_cur_en === 1'b1) begin
         cur_seen <= 1'b1;
      end
   end

   // A short pause step keeps channel pauses to a few cycles.
   ods_seq #(.PAUSE_STEP(4)) u_ods_seq (
      .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .zc_l1(zc_l1), .ctl_pattern(ctl_pattern),
      .ch_present(ch_present), .meas(meas), .sw_out(sw_out),
      .meas_cur_en(meas_cur_en), .report(report)
   );

   ods_mains_master u_ods_mains_master (
      .pclk(pclk), .presetn(presetn), .report(report), .zc_l1(zc_l1),
      .rep_cnt(rep_cnt), .last(last)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic results;
      if (miscompares == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // One APB transfer; the request is held until pready is seen at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      chk({31'h0, pready}, 32'h1, "apb answer");
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Waits, bounded, for the next report and compares it whole.
   task automatic rep(input logic [4:0] ch, input ods_fault_t code, input logic job);
      int c0;
      int n;
      c0 = rep_cnt;
      n = 0;
      while (rep_cnt == c0 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(last), 32'({1'b1, job, ch, code}), "report");
   endtask

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0, rd, err);
         chk(rd, 32'h0, "reset value");
      end
      apb(1'b0, 8'h40, 32'h0, rd, err);
      chk({31'h0, err}, 32'h1, "unmapped refused");
      // Channel 9 sits in a disabled field and must never be reported.
      apb(1'b1, OFS_FIELD_EN, 32'h1, rd, err);
      apb(1'b1, OFS_CH_EN, 32'h20A, rd, err);
      apb(1'b1, OFS_CH_EXT, 32'h8, rd, err);
      apb(1'b1, OFS_TIMING, 32'h0001_0101, rd, err);
      apb(1'b1, OFS_POWER, 32'h0010_0200, rd, err);
      meas <= '{1'b0, 1'b1, 1'b0, 16'h1000, 16'h1000};
      apb(1'b1, OFS_CTRL, 32'h12, rd, err);
      // One repeat is asked for, so the first detection of channel 1 must stay silent.
      repeat (250) @(posedge pclk);
      chk(rep_cnt, 32'h0, "no early report");
      chk({31'h0, cur_seen}, 32'h1, "current measured");
      rep(5'd1, FLT_T1, 1'b0);
      rep(5'd3, FLT_T3, 1'b0);
      repeat (60) @(posedge pclk);
      apb(1'b0, OFS_STATUS, 32'h0, rd, err);
      chk(rd & 32'h0002_0000, 32'h0002_0000, "cycle pause");
      rep(5'd1, FLT_T1, 1'b0);
      apb(1'b1, OFS_CTRL, 32'h10, rd, err);
      apb(1'b0, OFS_STATUS, 32'h0, rd, err);
      chk(rd & 32'h7F, 32'h01, "idle when off");
      apb(1'b0, OFS_FAULT, 32'h0, rd, err);
      chk(rd, 32'h8000_0101, "fault register");
      apb(1'b1, OFS_FIELD_EN, 32'h0, rd, err);
      meas <= '{1'b0, 1'b0, 1'b0, 16'h1000, 16'h1000};
      ch_present <= 24'h000020;
      apb(1'b1, OFS_CTRL, 32'h110, rd, err);
      rep(5'd5, FLT_T2EXT, 1'b1);
      apb(1'b0, OFS_FAULT, 32'h0, rd, err);
      chk(rd, 32'h8000_0101, "job not stored");
      repeat (4) @(posedge pclk);
      chk(32'(sw_out), 32'(ctl_pattern), "normal control");
      // Second job on a relay unit with the parameterised voltage.
      meas <= '{1'b0, 1'b1, 1'b1, 16'h1000, 16'h1000};
      ch_present <= 24'h000028;
      apb(1'b1, OFS_VOLT, 32'h4000, rd, err);
      apb(1'b1, OFS_CTRL, 32'h120, rd, err);
      rep(5'd3, FLT_T4, 1'b1);
      rep(5'd5, FLT_T5, 1'b1);
      results();
   end

   // The whole sequence needs a few thousand cycles; this bound cuts a hang.
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      results();
   end
endmodule // tb_top
